// ### shared/bus_pins_pkg.sv
// constants for the processor external bus pin block
// assumes a single clock domain driven by clk_in (the 4x clock input)
package bus_pins_pkg;
  localparam int          ADDR_W        = 14;
  localparam int          DATA_W        = 8;
  localparam int          PHASE_COUNT   = 4;
  localparam logic [1:0]  PHASE_RST     = 2'h0;
  localparam logic [1:0]  PHASE_THREE   = 2'h2;
  localparam logic [13:0] ADDR_RST      = 14'h0000;
  localparam logic [7:0]  DATA_RST      = 8'h00;
  // cycle kinds requested by the core side
  typedef enum logic [1:0] {
    CYC_NONE,
    CYC_MEM,
    CYC_SERIAL,
    CYC_EXT
  } cycle_kind_e;
endpackage : bus_pins_pkg

// ### verilog/phase_gen.sv
// four-phase clock generator from the 4x clock input
// assumes clk_in is the clock input pin, counted on every rising edge
module phase_gen
  import bus_pins_pkg::*;
(
  input  wire logic       clk_in,
  input  wire logic       nrst_in,
  output logic [1:0]      phase_out,
  output logic            phase3_n_out
);
  logic [1:0] phase_r;

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      phase_r <= PHASE_RST;
    end else begin
      phase_r <= phase_r + 2'h1;
    end
  end

  // registered so the timing output has no decode glitches
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      phase3_n_out <= 1'b1;
    end else begin
      phase3_n_out <= ~((phase_r + 2'h1) == PHASE_THREE);
    end
  end

  assign phase_out = phase_r;
endmodule : phase_gen

// ### verilog/bus_pins.sv
// external bus pin block: address, data, direction, hold and strobes
// assumes the core presents cycle requests synchronous to clk_in;
// the bench resolves only the data pins from data_oe_out; other pins are read as driven
// Functional notes
// - 14-line address bus, line 0 most significant
// - memory address or serial/external address per cycle
// - address bus floats during bus grant ack
// - serial output bit on line 13
// - external instruction code bit on line 13
// - 8-line bidirectional data bus, line 0 msb
// - data bus carries memory write or read data
// - data bus floats during bus grant ack
// - internal four phases from clock input
// - inverted phase three output for timing
// - data-in direction high when drivers off reading
// - direction low otherwise, floats during ack
// - memory cycle enable low marks memory address
// - bus grant ack only in hold state
// - serial strobe active high for sample/decode
module bus_pins
  import bus_pins_pkg::*;
#(
  parameter int AW = ADDR_W,
  parameter int DW = DATA_W
) (
  input  wire logic          clk_in,
  input  wire logic          nrst_in,
  // core side
  input  wire logic [1:0]    cycle_kind_in,
  input  wire logic          cycle_write_in,
  input  wire logic [AW-1:0] cycle_addr_in,
  input  wire logic [DW-1:0] cycle_wdata_in,
  input  wire logic          serial_bit_in,
  input  wire logic          ext_code_bit_in,
  input  wire logic          hold_req_in,
  output logic [DW-1:0]      read_data_out,
  output logic               read_valid_out,
  output logic               cycle_done_out,
  output logic [1:0]         phase_out,
  // pin side
  output logic [AW-1:0]      addr_out,
  output logic               addr_oe_out,
  input  wire logic [DW-1:0] data_in,
  output logic [DW-1:0]      data_out,
  output logic               data_oe_out,
  output logic               memory_cycle_enable_n_out,
  output logic               memory_cycle_enable_oe_out,
  output logic               data_in_direction_out,
  output logic               data_in_direction_oe_out,
  output logic               serial_io_strobe_out,
  output logic               bus_grant_ack_out,
  output logic               phase3_n_out
);
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_MEM,
    ST_IO,
    ST_HOLD
  } bus_state_e;

  bus_state_e    state_r;
  logic [1:0]    phase;
  logic          last_phase;
  logic [AW-1:0] addr_r;
  logic [DW-1:0] wdata_r;
  logic          write_r;

  phase_gen u_phase (
    .clk_in       (clk_in),
    .nrst_in      (nrst_in),
    .phase_out    (phase),
    .phase3_n_out (phase3_n_out)
  );

  assign phase_out  = phase;
  assign last_phase = (phase == 2'(PHASE_COUNT - 1));

  // one bus cycle per four-phase machine cycle; hold taken between cycles
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state_r <= ST_IDLE;
    end else if (last_phase) begin
      if (hold_req_in) begin
        state_r <= ST_HOLD;
      end else begin
        case (cycle_kind_e'(cycle_kind_in))
          CYC_MEM:    state_r <= ST_MEM;
          CYC_SERIAL: state_r <= ST_IO;
          CYC_EXT:    state_r <= ST_IO;
          default:    state_r <= ST_IDLE;
        endcase
      end
    end
  end

  // latched at the boundary so the pins stand still for the whole cycle
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      addr_r <= ADDR_RST;
    end else if (last_phase) begin
      addr_r <= cycle_addr_in;
      // line 13 is the lsb: it carries the serial or code bit on io cycles
      if (cycle_kind_in == CYC_SERIAL) begin
        addr_r[0] <= serial_bit_in;
      end else if (cycle_kind_in == CYC_EXT) begin
        addr_r[0] <= ext_code_bit_in;
      end
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      wdata_r <= DATA_RST;
    end else if (last_phase) begin
      wdata_r <= cycle_wdata_in;
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      write_r <= 1'b0;
    end else if (last_phase) begin
      write_r <= cycle_write_in;
    end
  end

  // read data captured at the end of the memory cycle
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      read_data_out <= DATA_RST;
    end else if (state_r == ST_MEM && !write_r && last_phase) begin
      read_data_out <= data_in;
    end
  end

  // one-clock pulse while the captured byte is fresh
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      read_valid_out <= 1'b0;
    end else begin
      read_valid_out <= (state_r == ST_MEM) && !write_r && last_phase;
    end
  end

  // strobe sits mid-cycle so line 13 is settled before it rises
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      serial_io_strobe_out <= 1'b0;
    end else begin
      serial_io_strobe_out <= (state_r == ST_IO) && (phase == 2'h0);
    end
  end

  assign cycle_done_out = last_phase && (state_r == ST_MEM || state_r == ST_IO);

  assign bus_grant_ack_out          = (state_r == ST_HOLD);
  assign addr_out                   = addr_r;
  assign addr_oe_out                = (state_r != ST_HOLD);
  assign data_out                   = wdata_r;
  assign data_oe_out                = (state_r == ST_MEM) && write_r;
  assign memory_cycle_enable_n_out  = (state_r != ST_MEM);
  assign memory_cycle_enable_oe_out = (state_r != ST_HOLD);
  assign data_in_direction_out      = (state_r == ST_MEM) && !write_r;
  assign data_in_direction_oe_out   = (state_r != ST_HOLD);
endmodule : bus_pins

// ### verification/far_mem.sv
// far-side memory on the data pins
// assumes the bench merges it with the block's drivers
module far_mem #(parameter logic [7:0] RDATA = 8'hc3) (
  input  wire logic       rd_in,
  input  wire logic       strobe_in,
  input  wire logic       line13_in,
  output logic      [7:0] bus_out,
  output logic            io_bit_out
);
  timeunit 1ns / 1ns;
  assign bus_out = rd_in ? RDATA : ~RDATA; // junk once released
  // io side latches the serial line as the strobe rises
  always @(posedge strobe_in) io_bit_out <= line13_in;
endmodule : far_mem

// ### verification/bus_pins_chk.sv
// pin timing checker for bus_pins
// assumes bind into bus_pins
module bus_pins_chk (
  input wire logic       clk_in,
  input wire logic       nrst_in,
  input wire logic [1:0] phase_out,
  input wire logic       phase3_n_out,
  input wire logic       addr_oe_out,
  input wire logic       data_oe_out,
  input wire logic       memory_cycle_enable_n_out,
  input wire logic       data_in_direction_out,
  input wire logic       serial_io_strobe_out,
  input wire logic       bus_grant_ack_out
);
  timeunit 1ns / 1ns;
  default clocking @(posedge clk_in); endclocking
  default disable iff (!nrst_in);
  a_addr_float: assert property (bus_grant_ack_out |-> !addr_oe_out) else $error("addr");
  a_data_float: assert property (bus_grant_ack_out |-> !data_oe_out) else $error("data");
  a_dir_read: assert property (data_in_direction_out |-> !memory_cycle_enable_n_out)
    else $error("dir");
  a_dir_write: assert property (data_oe_out |-> !data_in_direction_out)
    else $error("wr");
  a_phase_wrap: assert property (phase_out == 2'h3 |=> phase_out == 2'h0) else $error("ph");
  a_phase3_pin: assert property (phase3_n_out == (phase_out != 2'h2)) else $error("p3");
  a_strobe_one: assert property (serial_io_strobe_out |->
    phase_out == 2'h1 ##1 !serial_io_strobe_out) else $error("strobe");
  a_ack_edge: assert property ($rose(bus_grant_ack_out) |-> phase_out == 2'h0)
    else $error("ack");
endmodule : bus_pins_chk
bind bus_pins bus_pins_chk chk_u (.*);

// ### verification/bus_pins_test.sv
// bench for bus_pins: memory, io and hold cycles
// assumes far_mem answers reads
module bus_pins_test;
  timeunit 1ns / 1ns;
  logic clk_in = 1'b0, nrst_in = 1'b0, cycle_write_in = 1'b0, serial_bit_in = 1'b0;
  logic ext_code_bit_in = 1'b0, hold_req_in = 1'b0, read_valid_out, cycle_done_out, io_bit;
  logic addr_oe_out, data_oe_out, phase3_n_out;
  logic memory_cycle_enable_n_out, memory_cycle_enable_oe_out, data_in_direction_out;
  logic data_in_direction_oe_out, serial_io_strobe_out, bus_grant_ack_out;
  logic [1:0] cycle_kind_in = 2'h0, phase_out;
  logic [13:0] cycle_addr_in = 14'h2a5c, addr_out;
  logic [7:0] cycle_wdata_in = 8'h96, data_in, data_out, read_data_out, mem_bus;
  int n_errors = 0, n_compared = 0, ticks = 0;
  bus_pins dut_u (.*);
  far_mem mem_u (
    .rd_in      (data_in_direction_out),
    .strobe_in  (serial_io_strobe_out),
    .line13_in  (addr_out[0]),
    .bus_out    (mem_bus),
    .io_bit_out (io_bit)
  );
  assign data_in = data_oe_out ? data_out : mem_bus;
  initial forever #50 clk_in = ~clk_in;
  task automatic check(input logic [15:0] got, exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: %h not %h", $time, got, exp);
    end
  endtask : check
  task automatic issue(input logic [1:0] k);
    for (int i = 0; i < 8 && phase_out !== 2'h3; i++) @(negedge clk_in);
    cycle_kind_in = k;
    @(negedge clk_in);
    cycle_kind_in = 2'h0;
  endtask : issue
  task automatic mem_test(input logic w);
    cycle_write_in = w;
    issue(2'h1);
    check({addr_out, memory_cycle_enable_n_out}, {14'h2a5c, 1'b0});
    check({data_oe_out, data_in_direction_out}, {w, !w});
    if (w) check(data_out, 8'h96);
    repeat (3) @(negedge clk_in);
    check(cycle_done_out, 1'b1);
    @(negedge clk_in);
    if (!w) check({read_valid_out, read_data_out}, {1'b1, 8'hc3});
    $display("mem test done");
  endtask : mem_test
  task automatic io_test(input logic [1:0] k, input logic b);
    {serial_bit_in, ext_code_bit_in} = {b, b};
    issue(k);
    check({memory_cycle_enable_n_out, data_in_direction_out}, 2'h2);
    @(negedge clk_in);
    check({serial_io_strobe_out, addr_out[0]}, {1'b1, b});
    check(addr_out, {13'h152e, b});
    check(io_bit, b);
    $display("io test done");
  endtask : io_test
  task automatic hold_test;
    hold_req_in = 1'b1;
    repeat (9) @(negedge clk_in);
    check({bus_grant_ack_out, addr_oe_out, data_oe_out}, 3'h4);
    check({memory_cycle_enable_oe_out, data_in_direction_oe_out}, 2'h0);
    hold_req_in = 1'b0;
    repeat (9) @(negedge clk_in);
    check({bus_grant_ack_out, addr_oe_out}, 2'h1);
    $display("hold test done");
  endtask : hold_test
  task automatic give_verdict;
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : give_verdict
  initial begin
    repeat (20) @(negedge clk_in);
    nrst_in = 1;
    mem_test(1);
    mem_test(0);
    for (int k = 2; k < 4; k++) for (int b = 0; b < 2; b++) io_test(2'(k), 1'(b));
    hold_test;
    give_verdict;
  end
  always @(posedge clk_in) if (++ticks == 2000) begin
    n_errors++;
    $display("unexpected at %0t: run did not finish in time", $time);
    give_verdict;
  end
endmodule : bus_pins_test
